// ===== lp_ctl_cfg.svh
`ifndef LP_CTL_CFG_SVH
`define LP_CTL_CFG_SVH

// register offsets on the plain register port
`define ADDR_OPT 5'h00
`define ADDR_PA_DATA 5'h01
`define ADDR_PA_DIR 5'h02
`define ADDR_PB_DATA 5'h03
`define ADDR_PB_DIR 5'h04
`define ADDR_PC_DATA 5'h05
`define ADDR_PC_DIR 5'h06
`define ADDR_PC_CFG 5'h07
`define ADDR_PD_DATA 5'h08
`define ADDR_PD_CFG 5'h09
`define ADDR_PG_IN 5'h0a
`define ADDR_KBD_EN 5'h0b
`define ADDR_KBD_FLAG 5'h0c
`define ADDR_PWR_STAT 5'h0d

// option register fields
`define OPT_IRQ_SENSE 0
`define OPT_LVI_HW 1
`define OPT_LVI_EN 2
`define OPT_MASK 8'h07

// keyboard-port configuration fields
`define PC_CFG_TIMER_CAPTURE_INPUT 0
`define PC_CFG_TIMER_COMPARE_OUTPUT 1
`define PC_CFG_MASK 8'h03
`define PC_CAP_LINE 0
`define PC_CMP_LINE 1

// reset values
`define RST_BYTE 8'h00
`define RST_BUS 1'b0
`define RST_PULL 8'hff
`define RST_PIN_IDLE 1'b1

// restart delay after deep sleep, in clock cycles
`define RESTART_CYCLES 4064
`define RESTART_W 12
`define RESTART_LAST 12'hfdf

`endif

// ===== lp_ctl_pkg.sv
package lp_ctl_pkg;

  typedef enum logic [2:0] {
    PWR_RUN,
    PWR_IDLE,
    PWR_SLEEP,
    PWR_RESTART,
    PWR_SERVICE
  } pwr_state_t;

  // per-port pin drive: level and output enable for each of eight lines
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } port_drive_t;

  // wake sources, already qualified by their enables
  typedef struct packed {
    logic extIrq;
    logic kbd;
    logic lowVolt;
    logic coreTimer;
    logic timer16;
  } wake_src_t;

endpackage

// ===== irq_sense.sv
`timescale 1ns/10ps
`include "lp_ctl_cfg.svh"

module irq_sense (
  input wire logic mclk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic pinN, // external interrupt pin, active low
  input wire logic levelMode, // 1: edge and low level, 0: falling edge only
  input wire logic ack, // core has taken the interrupt
  output logic req // pending external interrupt
);

  logic pinPrev_r;
  logic edgeLatch_r;
  logic fallEdge;

  assign fallEdge = pinPrev_r & ~pinN;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pinPrev_r <= `RST_PIN_IDLE;
    end else begin
      pinPrev_r <= pinN;
    end
  end

  // a new edge in the ack cycle is kept
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      edgeLatch_r <= `RST_BUS;
    end else if (fallEdge) begin
      edgeLatch_r <= 1'b1;
    end else if (ack) begin
      edgeLatch_r <= 1'b0;
    end
  end

  // in level mode a held-low pin keeps requesting after the ack
  assign req = edgeLatch_r | (levelMode & ~pinN);

endmodule // irq_sense

// ===== restart_counter.sv
`timescale 1ns/10ps
`include "lp_ctl_cfg.svh"

module restart_counter (
  input wire logic mclk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic start, // begin the restart delay
  output logic busy, // delay running
  output logic done // one-cycle pulse in the last delay cycle
);

  logic [`RESTART_W-1:0] count_r;
  logic busy_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      count_r <= '0;
    end else if (start) begin
      busy_r <= 1'b1;
      count_r <= '0;
    end else if (busy_r) begin
      count_r <= count_r + 1'b1;
      if (count_r == `RESTART_LAST) begin
        busy_r <= 1'b0;
      end
    end
  end

  assign busy = busy_r;
  assign done = busy_r & (count_r == `RESTART_LAST);

endmodule // restart_counter

// ===== lowpower_pin_ctl.sv
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "lp_ctl_cfg.svh"


module lowpower_pin_ctl (
  input wire logic mclk, // system clock, 200 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic [4:0] addr, // register address
  input wire logic [7:0] wrData, // register write data
  input wire logic wrStb, // register write strobe
  input wire logic rdStb, // register read strobe
  output logic [7:0] rdData, // read data, cycle after rdStb
  input wire logic irqPinN, // external interrupt pin, active low
  input wire logic supplyDropIndicatorN, // supply-drop indicator pin, active low
  input wire logic irqAck, // core took the external interrupt
  input wire logic stopExec, // core executes the deep-sleep instruction
  input wire logic waitExec, // core executes the idle instruction
  input wire logic stopOptDis, // manufacturing option: deep sleep disabled
  input wire logic coreTimerIrq, // enabled core timer interrupt
  input wire logic timer16Irq, // enabled 16-bit timer interrupt
  input wire logic timerCompareOutput, // compare level from the timer
  output logic busClk, // oscillator divided by two
  output logic oscRun, // oscillator running
  output logic cpuHalt, // processor activity stopped
  output logic timersRun, // core timer, 16-bit timer and converter clocked
  output logic watchdogRun, // watchdog clocked
  output logic clearIMask, // pulse: clear interrupt mask bit in condition_code_reg
  output logic wakeService, // pulse: service the waking interrupt now
  output logic irqReq, // external interrupt request
  output logic lviIrq, // supply-drop hardware interrupt request
  output logic lviSoftReq, // supply-drop software routine request
  output logic kbdIrq, // keyboard interrupt request
  output logic timerCaptureInput, // capture input to the timer
  input wire logic [7:0] pullupPortIn, // pull-up port pin levels
  output lp_ctl_pkg::port_drive_t pullupPortDrv, // pull-up port pin drive
  input wire logic [7:0] pulldownPortIn, // pull-down port pin levels
  output lp_ctl_pkg::port_drive_t pulldownPortDrv, // pull-down port pin drive
  input wire logic [7:0] keyboardPortIn, // keyboard port pin levels
  output lp_ctl_pkg::port_drive_t keyboardPortDrv, // keyboard port pin drive
  output logic [7:0] keyboardPullEn, // keyboard port pull-up enables
  input wire logic [7:0] fourthPortIn, // fourth port pin levels
  output lp_ctl_pkg::port_drive_t fourthPortDrv, // fourth port pin drive
  output logic [7:0] fourthPullEn, // fourth port pull-up enables
  input wire logic [3:0] inputOnlyPortIn, // input-only port pin levels
  output logic [3:0] converterChannelInputs // converter channels 0 to 3
);

  lp_ctl_pkg::pwr_state_t state_r;
  lp_ctl_pkg::pwr_state_t state_nxt;
  lp_ctl_pkg::wake_src_t wake;

  logic [7:0] opt_r;
  logic [7:0] paData_r;
  logic [7:0] paDir_r;
  logic [7:0] pbData_r;
  logic [7:0] pbDir_r;
  logic [7:0] pcData_r;
  logic [7:0] pcDir_r;
  logic [7:0] pcCfg_r;
  logic [7:0] pdData_r;
  logic [7:0] pdCfg_r;
  logic [7:0] kbdEn_r;
  logic [7:0] kbdFlag_r;
  logic [7:0] kbdPrev_r;
  logic [7:0] kbdSet;
  logic [7:0] kbdEligible;
  logic [7:0] rdData_r;
  logic busClk_r;
  logic restartBusy;
  logic restartDone;
  logic restartStart;
  logic lviLow;
  logic stopWake;
  logic idleWake;

  // register writes; reset returns every port to plain inputs
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      opt_r <= `RST_BYTE;
      paData_r <= `RST_BYTE;
      paDir_r <= `RST_BYTE;
      pbData_r <= `RST_BYTE;
      pbDir_r <= `RST_BYTE;
      pcData_r <= `RST_BYTE;
      pcDir_r <= `RST_BYTE;
      pcCfg_r <= `RST_BYTE;
      pdData_r <= `RST_BYTE;
      pdCfg_r <= `RST_BYTE;
      kbdEn_r <= `RST_BYTE;
    end else if (wrStb) begin
      unique case (addr)
        `ADDR_OPT: opt_r <= wrData & `OPT_MASK;
        `ADDR_PA_DATA: paData_r <= wrData;
        `ADDR_PA_DIR: paDir_r <= wrData;
        `ADDR_PB_DATA: pbData_r <= wrData;
        `ADDR_PB_DIR: pbDir_r <= wrData;
        `ADDR_PC_DATA: pcData_r <= wrData;
        `ADDR_PC_DIR: pcDir_r <= wrData;
        `ADDR_PC_CFG: pcCfg_r <= wrData & `PC_CFG_MASK;
        `ADDR_PD_DATA: pdData_r <= wrData;
        `ADDR_PD_CFG: pdCfg_r <= wrData;
        `ADDR_KBD_EN: kbdEn_r <= wrData;
        default: ;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdData_r <= `RST_BYTE;
    end else if (rdStb) begin
      unique case (addr)
        `ADDR_OPT: rdData_r <= opt_r;
        `ADDR_PA_DATA: rdData_r <= (paData_r & paDir_r) | (pullupPortIn & ~paDir_r);
        `ADDR_PA_DIR: rdData_r <= paDir_r;
        `ADDR_PB_DATA: rdData_r <= (pbData_r & pbDir_r) | (pulldownPortIn & ~pbDir_r);
        `ADDR_PB_DIR: rdData_r <= pbDir_r;
        `ADDR_PC_DATA: rdData_r <= keyboardPortIn;
        `ADDR_PC_DIR: rdData_r <= pcDir_r;
        `ADDR_PC_CFG: rdData_r <= pcCfg_r;
        `ADDR_PD_DATA: rdData_r <= fourthPortIn;
        `ADDR_PD_CFG: rdData_r <= pdCfg_r;
        `ADDR_PG_IN: rdData_r <= {4'h0, inputOnlyPortIn};
        `ADDR_KBD_EN: rdData_r <= kbdEn_r;
        `ADDR_KBD_FLAG: rdData_r <= kbdFlag_r;
        `ADDR_PWR_STAT: rdData_r <= {5'h00, state_r};
        default: rdData_r <= `RST_BYTE;
      endcase
    end else begin
      rdData_r <= `RST_BYTE;
    end
  end

  assign rdData = rdData_r;

  // bus clock divider; it halts with the oscillator in deep sleep
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busClk_r <= `RST_BUS;
    end else if (state_r != lp_ctl_pkg::PWR_SLEEP) begin
      busClk_r <= ~busClk_r;
    end
  end

  assign busClk = busClk_r;

  // external interrupt sensing
  irq_sense u_irq_sense (
    .mclk(mclk),
    .nrst(nrst),
    .pinN(irqPinN),
    .levelMode(opt_r[`OPT_IRQ_SENSE]),
    .ack(irqAck),
    .req(irqReq)
  );

  // supply drop: enabled, it goes to the interrupt or to the software routine
  assign lviLow = ~supplyDropIndicatorN & opt_r[`OPT_LVI_EN];
  assign lviIrq = lviLow & opt_r[`OPT_LVI_HW];
  assign lviSoftReq = lviLow & ~opt_r[`OPT_LVI_HW];

  // a line used by the timer never feeds the keyboard logic
  always_comb begin
    kbdEligible = ~pcDir_r & kbdEn_r;
    if (pcCfg_r[`PC_CFG_TIMER_CAPTURE_INPUT]) begin
      kbdEligible[`PC_CAP_LINE] = 1'b0;
    end
    if (pcCfg_r[`PC_CFG_TIMER_COMPARE_OUTPUT]) begin
      kbdEligible[`PC_CMP_LINE] = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      kbdPrev_r <= `RST_PULL;
    end else begin
      kbdPrev_r <= keyboardPortIn;
    end
  end

  // sticky per-line flags, write one to clear; a fresh edge beats the clear
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_kbd
      assign kbdSet[i] = kbdEligible[i] & kbdPrev_r[i] & ~keyboardPortIn[i];
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          kbdFlag_r[i] <= `RST_BUS;
        end else if (kbdSet[i]) begin
          kbdFlag_r[i] <= 1'b1;
        end else if (wrStb && addr == `ADDR_KBD_FLAG && wrData[i]) begin
          kbdFlag_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign kbdIrq = |kbdFlag_r;

  // timer sharing of the keyboard port
  assign timerCaptureInput = keyboardPortIn[`PC_CAP_LINE];

  // pin drivers are registered so that pins never glitch on decode
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pullupPortDrv <= '0;
    end else begin
      pullupPortDrv.out <= paData_r;
      pullupPortDrv.oe <= paDir_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pulldownPortDrv <= '0;
    end else begin
      pulldownPortDrv.out <= pbData_r;
      pulldownPortDrv.oe <= pbDir_r;
    end
  end

  // open drain: a line set as output only ever pulls low
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      keyboardPortDrv <= '0;
      keyboardPullEn <= `RST_PULL;
    end else begin
      keyboardPortDrv.out <= '0;
      keyboardPortDrv.oe <= pcDir_r & ~pcData_r;
      keyboardPullEn <= ~pcDir_r;
      if (pcCfg_r[`PC_CFG_TIMER_COMPARE_OUTPUT]) begin
        keyboardPortDrv.oe[`PC_CMP_LINE] <= ~timerCompareOutput;
        keyboardPullEn[`PC_CMP_LINE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fourthPortDrv <= '0;
      fourthPullEn <= `RST_PULL;
    end else begin
      fourthPortDrv.out <= '0;
      fourthPortDrv.oe <= pdCfg_r & ~pdData_r;
      fourthPullEn <= ~pdCfg_r;
    end
  end

  assign converterChannelInputs = inputOnlyPortIn;

  // wake sources
  assign wake.extIrq = irqReq;
  assign wake.kbd = kbdIrq;
  assign wake.lowVolt = lviIrq;
  assign wake.coreTimer = coreTimerIrq;
  assign wake.timer16 = timer16Irq;

  assign stopWake = wake.extIrq | wake.kbd | wake.lowVolt;
  assign idleWake = stopWake | wake.coreTimer | wake.timer16;

  // power sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      lp_ctl_pkg::PWR_RUN: begin
        if (stopExec && !stopOptDis) begin
          state_nxt = lp_ctl_pkg::PWR_SLEEP;
        end else if (waitExec) begin
          state_nxt = lp_ctl_pkg::PWR_IDLE;
        end
      end
      lp_ctl_pkg::PWR_SLEEP: begin
        if (stopWake) begin
          state_nxt = lp_ctl_pkg::PWR_RESTART;
        end
      end
      lp_ctl_pkg::PWR_RESTART: begin
        if (restartDone) begin
          state_nxt = lp_ctl_pkg::PWR_SERVICE;
        end
      end
      lp_ctl_pkg::PWR_IDLE: begin
        if (idleWake) begin
          state_nxt = lp_ctl_pkg::PWR_SERVICE;
        end
      end
      lp_ctl_pkg::PWR_SERVICE: begin
        state_nxt = lp_ctl_pkg::PWR_RUN;
      end
      default: state_nxt = lp_ctl_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= lp_ctl_pkg::PWR_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign restartStart = (state_r == lp_ctl_pkg::PWR_SLEEP) && stopWake;

  restart_counter u_restart (
    .mclk(mclk),
    .nrst(nrst),
    .start(restartStart),
    .busy(restartBusy),
    .done(restartDone)
  );

  // mask clear pulses once on entry; registers and pins are left alone
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clearIMask <= `RST_BUS;
    end else begin
      clearIMask <= (state_r == lp_ctl_pkg::PWR_RUN)
                    && ((stopExec && !stopOptDis) || waitExec);
    end
  end

  // the core vectors to the pending interrupt before its next instruction
  assign wakeService = (state_r == lp_ctl_pkg::PWR_SERVICE);

  // deep sleep stops the oscillator-fed logic; restart stops only the processor and timers
  assign oscRun = (state_r != lp_ctl_pkg::PWR_SLEEP);
  assign cpuHalt = (state_r == lp_ctl_pkg::PWR_SLEEP) || (state_r == lp_ctl_pkg::PWR_IDLE)
                   || restartBusy;
  assign timersRun = (state_r != lp_ctl_pkg::PWR_SLEEP) && !restartBusy;
  assign watchdogRun = (state_r != lp_ctl_pkg::PWR_SLEEP);

endmodule // lowpower_pin_ctl

// ===== pin_drivers.sv
`timescale 1ns/10ps

// far side: interrupt and supply-drop pins, changed just after the clock edge
module pin_drivers (
  input wire logic mclk, // system clock
  input wire logic irqLow, // pull the interrupt pin low
  input wire logic lviLow, // pull the supply-drop pin low
  output logic irqPinN, // external interrupt pin, active low
  output logic supplyDropIndicatorN // supply-drop pin, active low
);
  initial begin
    irqPinN = 1'b1;
    supplyDropIndicatorN = 1'b1;
  end
  // plain always: the initial block gives the pins their idle level first
  always @(posedge mclk) begin
    irqPinN <= !irqLow;
    supplyDropIndicatorN <= !lviLow;
  end
endmodule // pin_drivers

// ===== lp_ctl_chk.sv
`timescale 1ns/10ps

module lp_ctl_chk (
  input wire logic mclk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic irqPinN, // interrupt pin
  input wire logic supplyDropIndicatorN, // supply-drop pin
  input wire logic stopExec, // deep-sleep instruction
  input wire logic waitExec, // idle instruction
  input wire logic stopOptDis, // deep sleep disabled
  input wire logic coreTimerIrq, // core timer interrupt
  input wire logic timer16Irq, // 16-bit timer interrupt
  input wire logic busClk, // divided clock
  input wire logic oscRun, // oscillator running
  input wire logic cpuHalt, // processor stopped
  input wire logic timersRun, // timers clocked
  input wire logic watchdogRun, // watchdog clocked
  input wire logic clearIMask, // mask clear pulse
  input wire logic wakeService, // service pulse
  input wire logic irqReq, // external request
  input wire logic lviIrq, // supply-drop interrupt
  input wire logic lviSoftReq, // supply-drop software request
  input wire logic kbdIrq, // keyboard interrupt
  input wire logic timerCaptureInput, // timer capture
  input wire logic [7:0] keyboardPortIn, // keyboard pins
  input wire logic [3:0] inputOnlyPortIn, // input-only pins
  input wire logic [3:0] converterChannelInputs // converter channels
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic restartNow;
  logic [12:0] restartCnt_r;
  logic runNow;
  assign restartNow = cpuHalt && oscRun && !timersRun;
  assign runNow = !cpuHalt && !wakeService;
  always_ff @(posedge mclk) begin
    if (!nrst) restartCnt_r <= 13'h0000;
    else restartCnt_r <= restartNow ? restartCnt_r + 13'h0001 : 13'h0000;
  end

  sequence s_service;
    wakeService ##1 (!wakeService && !cpuHalt);
  endsequence

  property p_div; oscRun |=> busClk != $past(busClk); endproperty
  a_div: assert property (p_div) else $error("bus clock did not toggle");
  property p_sleep; !oscRun |-> !watchdogRun && !timersRun && cpuHalt; endproperty
  a_sleep: assert property (p_sleep) else $error("activity in deep sleep");
  property p_stop; stopExec && !stopOptDis && runNow |=> !oscRun && clearIMask; endproperty
  a_stop: assert property (p_stop) else $error("deep sleep not entered");
  property p_nostop; stopExec && stopOptDis && !waitExec && runNow |=> oscRun && !cpuHalt && !clearIMask; endproperty
  a_nostop: assert property (p_nostop) else $error("disabled sleep acted");
  property p_hold; !oscRun && !irqReq && !kbdIrq && !lviIrq |=> !oscRun; endproperty
  a_hold: assert property (p_hold) else $error("woke without cause");
  property p_restart; $fell(restartNow) |-> restartCnt_r == 13'h0fe0 && wakeService; endproperty
  a_restart: assert property (p_restart) else $error("restart delay wrong");
  property p_wait; waitExec && !stopExec && runNow |=> cpuHalt && oscRun && timersRun && clearIMask; endproperty
  a_wait: assert property (p_wait) else $error("idle not entered");
  property p_idle_wake; cpuHalt && timersRun && (coreTimerIrq || timer16Irq) |=> s_service; endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");
  property p_edge; $fell(irqPinN) |-> ##[1:2] irqReq; endproperty
  a_edge: assert property (p_edge) else $error("falling edge missed");
  property p_lvi; lviIrq || lviSoftReq |-> !supplyDropIndicatorN && !(lviIrq && lviSoftReq); endproperty
  a_lvi: assert property (p_lvi) else $error("supply-drop request wrong");
  property p_cap; timerCaptureInput == keyboardPortIn[0]; endproperty
  a_cap: assert property (p_cap) else $error("capture input wrong");
  property p_conv; converterChannelInputs == inputOnlyPortIn; endproperty
  a_conv: assert property (p_conv) else $error("converter inputs wrong");
endmodule // lp_ctl_chk

bind lowpower_pin_ctl lp_ctl_chk chk (.mclk, .nrst, .irqPinN, .supplyDropIndicatorN, .stopExec, .waitExec,
  .stopOptDis, .coreTimerIrq, .timer16Irq, .busClk, .oscRun, .cpuHalt, .timersRun, .watchdogRun, .clearIMask,
  .wakeService, .irqReq, .lviIrq, .lviSoftReq, .kbdIrq, .timerCaptureInput, .keyboardPortIn,
  .inputOnlyPortIn, .converterChannelInputs);

// ===== low_power_mode_and_pin_reset_ctl_tb_top.sv
`timescale 1ns/10ps
`include "lp_ctl_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module low_power_mode_and_pin_reset_ctl_tb_top;
  logic mclk = 1'b0, nrst = 1'b0, wrStb = 1'b0, rdStb = 1'b0, irqAck = 1'b0;
  logic stopExec = 1'b0, waitExec = 1'b0, stopOptDis = 1'b0, coreTimerIrq = 1'b0;
  logic timer16Irq = 1'b0, timer_compare_output = 1'b0;
  logic irqLow = 1'b0, lviLow = 1'b0, irqPinN, supplyDropIndicatorN;
  logic [4:0] addr = 5'h00;
  logic [7:0] wrData = 8'h00, rdData, pullupIn = 8'hff, kbdExt = 8'hff, keyboardPortIn;
  logic [3:0] onlyIn = 4'h0, convIn;
  logic busClk, oscRun, cpuHalt, timersRun, watchdogRun, clearIMask, wakeService, irqReq, lviIrq, lviSoftReq;
  logic kbdIrq, capIn, b;
  logic [7:0] kbdPull, fourthPull;
  lp_ctl_pkg::port_drive_t upDrv, downDrv, kbdDrv, fourthDrv;
  int error_cnt = 0, n_checks = 0, n;

  always #2.5 mclk = ~mclk;
  // open-drain keyboard lines: a driven line wins over the outside level
  assign keyboardPortIn = (kbdDrv.oe & kbdDrv.out) | (~kbdDrv.oe & kbdExt);

  pin_drivers pins (.mclk(mclk), .irqLow(irqLow), .lviLow(lviLow), .irqPinN(irqPinN),
    .supplyDropIndicatorN(supplyDropIndicatorN));
  lowpower_pin_ctl dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .irqPinN(irqPinN), .supplyDropIndicatorN(supplyDropIndicatorN), .irqAck(irqAck),
    .stopExec(stopExec), .waitExec(waitExec), .stopOptDis(stopOptDis), .coreTimerIrq(coreTimerIrq),
    .timer16Irq(timer16Irq), .timerCompareOutput(timer_compare_output), .busClk(busClk), .oscRun(oscRun), .cpuHalt(cpuHalt),
    .timersRun(timersRun), .watchdogRun(watchdogRun), .clearIMask(clearIMask), .wakeService(wakeService),
    .irqReq(irqReq), .lviIrq(lviIrq), .lviSoftReq(lviSoftReq), .kbdIrq(kbdIrq), .timerCaptureInput(capIn),
    .pullupPortIn(pullupIn), .pullupPortDrv(upDrv), .pulldownPortIn(8'h00), .pulldownPortDrv(downDrv),
    .keyboardPortIn(keyboardPortIn), .keyboardPortDrv(kbdDrv), .keyboardPullEn(kbdPull),
    .fourthPortIn(8'hff), .fourthPortDrv(fourthDrv), .fourthPullEn(fourthPull), .inputOnlyPortIn(onlyIn),
    .converterChannelInputs(convIn));

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a; wrData <= d; wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a; rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1;
    `CHK(rdData, e)
  endtask
  task automatic exec(input bit stp);
    @(posedge mclk);
    if (stp) stopExec <= 1'b1; else waitExec <= 1'b1;
    @(posedge mclk);
    stopExec <= 1'b0; waitExec <= 1'b0;
    #1;
  endtask
  task automatic ack();
    @(posedge mclk);
    irqAck <= 1'b1;
    @(posedge mclk);
    irqAck <= 1'b0;
  endtask

  task automatic t_reset();
    `CHK(upDrv.oe, 8'h00)
    `CHK(downDrv.oe, 8'h00)
    `CHK({kbdDrv.oe, kbdPull}, 16'h00ff)
    `CHK({fourthDrv.oe, fourthPull}, 16'h00ff)
    rd(`ADDR_OPT, 8'h00);
    b = busClk;
    cyc(1);
    `CHK(busClk, ~b)
    $display("reset defaults done");
  endtask
  task automatic t_ports();
    wr(`ADDR_PA_DIR, 8'hff);
    wr(`ADDR_PA_DATA, 8'ha5);
    wr(`ADDR_PC_DIR, 8'h04);
    wr(`ADDR_PD_CFG, 8'h01);
    cyc(2);
    `CHK(upDrv, 16'ha5ff)
    `CHK(kbdDrv.oe, 8'h04)
    `CHK(fourthDrv.oe, 8'h01)
    onlyIn <= 4'ha;
    rd(`ADDR_PG_IN, 8'h0a);
    `CHK(convIn, 4'ha)
    rd(5'h1f, 8'h00);
    wr(`ADDR_PC_DIR, 8'h00);
    $display("port setup done");
  endtask
  task automatic t_irq();
    irqLow <= 1'b1;
    cyc(3);
    `CHK(irqReq, 1'b1)
    ack();
    cyc(1);
    `CHK(irqReq, 1'b0)
    irqLow <= 1'b0;
    wr(`ADDR_OPT, 8'h01);
    irqLow <= 1'b1;
    cyc(3);
    ack();
    cyc(1);
    `CHK(irqReq, 1'b1)
    irqLow <= 1'b0;
    wr(`ADDR_OPT, 8'h06);
    lviLow <= 1'b1;
    cyc(3);
    `CHK({lviIrq, lviSoftReq}, 2'b10)
    wr(`ADDR_OPT, 8'h04);
    cyc(1);
    `CHK({lviIrq, lviSoftReq}, 2'b01)
    lviLow <= 1'b0;
    wr(`ADDR_OPT, 8'h00);
    ack();
    $display("interrupt pins done");
  endtask
  task automatic t_kbd();
    kbdExt <= 8'hfe;
    cyc(2);
    `CHK(capIn, 1'b0)
    wr(`ADDR_KBD_EN, 8'h04);
    kbdExt <= 8'hfb;
    cyc(3);
    `CHK(kbdIrq, 1'b1)
    wr(`ADDR_KBD_FLAG, 8'h04);
    kbdExt <= 8'hff;
    cyc(1);
    `CHK(kbdIrq, 1'b0)
    wr(`ADDR_KBD_EN, 8'h03);
    wr(`ADDR_PC_CFG, 8'h03);
    kbdExt <= 8'hfe;
    cyc(3);
    `CHK({kbdDrv.oe[1], keyboardPortIn[1:0], kbdIrq}, 4'b1000)
    timer_compare_output <= 1'b1;
    cyc(2);
    `CHK(kbdDrv.oe[1], 1'b0)
    `CHK(kbdIrq, 1'b0)
    wr(`ADDR_PC_CFG, 8'h00);
    kbdExt <= 8'hff;
    timer_compare_output <= 1'b0;
    $display("keyboard done");
  endtask
  task automatic t_stop();
    stopOptDis <= 1'b1;
    exec(1'b1);
    cyc(1);
    `CHK({oscRun, cpuHalt}, 2'b10)
    stopOptDis <= 1'b0;
    exec(1'b1);
    `CHK({clearIMask, oscRun, watchdogRun, timersRun}, 4'b1000)
    rd(`ADDR_PWR_STAT, 8'h02);
    `CHK(upDrv, 16'ha5ff)
    cyc(20);
    `CHK(oscRun, 1'b0)
    irqLow <= 1'b1;
    n = 0;
    while (!oscRun && n < 8) begin cyc(1); n++; end
    n = 0;
    while (cpuHalt && n < 5000) begin cyc(1); n++; end
    `CHK(n, 4064)
    `CHK({wakeService, cpuHalt}, 2'b10)
    irqLow <= 1'b0;
    ack();
    rd(`ADDR_PA_DIR, 8'hff);
    $display("deep sleep done");
  endtask
  task automatic t_wait();
    exec(1'b0);
    `CHK({clearIMask, cpuHalt, timersRun, oscRun}, 4'b1111)
    cyc(5);
    `CHK(cpuHalt, 1'b1)
    `CHK(upDrv, 16'ha5ff)
    @(posedge mclk);
    coreTimerIrq <= 1'b1;
    @(posedge mclk);
    coreTimerIrq <= 1'b0;
    #1;
    `CHK({wakeService, cpuHalt}, 2'b10)
    exec(1'b0);
    @(posedge mclk);
    timer16Irq <= 1'b1;
    @(posedge mclk);
    timer16Irq <= 1'b0;
    #1;
    `CHK({wakeService, cpuHalt}, 2'b10)
    $display("idle done");
  endtask
  task automatic t_rst();
    wr(`ADDR_OPT, 8'h05);
    exec(1'b1);
    lviLow <= 1'b1;
    cyc(3);
    `CHK({oscRun, lviSoftReq}, 2'b01)
    lviLow <= 1'b0;
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    cyc(1);
    `CHK({oscRun, cpuHalt}, 2'b10)
    rd(`ADDR_OPT, 8'h00);
    $display("mid-sleep reset done");
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    cyc(1);
    t_reset();
    t_ports();
    t_irq();
    t_kbd();
    t_stop();
    t_wait();
    t_rst();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
endmodule // low_power_mode_and_pin_reset_ctl_tb_top
